/* logic/tcc_map.svh */
// Register indices, field positions, reset values and counts of the capture/compare block
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Register indices; the byte address is four times the index
`define TCC_IDX_CH0_LO 8'hda
`define TCC_IDX_CH0_HI 8'hdb
`define TCC_IDX_CH1_LO 8'hdc
`define TCC_IDX_CH1_HI 8'hdd
`define TCC_IDX_CTL0 8'he5
`define TCC_IDX_CTL1 8'he6
`define TCC_IDX_RFMASK 8'hf0
`define TCC_IDX_TMODE 8'hf1
`define TCC_IDX_ISTAT 8'hf2
`define TCC_IDX_IEN 8'hf3
`define TCC_IDX_CNT_LO 8'hf4
`define TCC_IDX_CNT_HI 8'hf5
`define TCC_ADDR(i) {i, 2'b00}
// Reset values
`define TCC_CTL_RST 8'h40
`define TCC_IEN_RST 2'h3
// Interrupt status bit positions
`define TCC_ST_CH1 0
`define TCC_ST_CH0 1
// Modulator step dividers, last count of the step divider dsm_cnt, which counts ticks
`define TCC_DSM_SLOW 3'h7
`define TCC_DSM_FAST 3'h3
// Modulator arithmetic
`define TCC_DSM_DW 14
`define TCC_DSM_LSB 2
`define TCC_INTERP_SHIFT 3
`define TCC_DSM_HALF 18'sh02000
`define TCC_DSM_FULL 18'sh04000
`endif

/* logic/tcc_pkg.sv */
// Types of the capture/compare block
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_CMP_SET = 3'b000,
    TCC_CMP_CLR = 3'b001,
    TCC_CMP_TGL = 3'b010,
    TCC_CMP_SETUP = 3'b011,
    TCC_CMP_CLRUP = 3'b100,
    TCC_CMP_SET1 = 3'b101,
    TCC_CMP_CLR1 = 3'b110,
    TCC_CMP_DSM = 3'b111
  } tcc_cmp_t;
  typedef enum logic [1:0] {
    TCC_MODE_STOP = 2'b00,
    TCC_MODE_FREE = 2'b01,
    TCC_MODE_MOD = 2'b10,
    TCC_MODE_UPDN = 2'b11
  } tcc_mode_t;
  typedef struct packed {
    logic capture_source_sel;
    logic chan_irq_mask;
    tcc_cmp_t compare_action;
    logic cap_cmp_sel;
    logic [1:0] capture_edge_sel;
  } tcc_ctl_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tcc_avm_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tcc_avm_rsp_t;
  typedef struct packed {
    logic [15:0] ch0_val;
    logic [15:0] ch1_val;
    tcc_ctl_t ch0_ctl;
    tcc_ctl_t ch1_ctl;
    logic [7:0] rf_mask;
    tcc_mode_t mode;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [15:0] count;
    logic down;
    logic [7:0] tick_cnt;
    logic [2:0] dsm_cnt;
    logic cap_s1;
    logic cap_s2;
    logic cap_prev;
    logic pin_out;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } tcc_state_t;
  typedef struct packed {
    logic [13:0] target;
    logic [13:0] cur;
    logic [13:0] acc;
    logic signed [17:0] e1;
    logic signed [17:0] e2;
    logic q;
  } tcc_dsm_state_t;
endpackage : tcc_pkg

/* logic/tcc_dsm.sv */
// Delta-sigma modulator with optional interpolator and second-order shaping
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_dsm (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control
  input wire logic enable,
  input wire logic step,
  input wire logic load,
  input wire logic interp_en,
  input wire logic shape_en,
  input wire logic [`TCC_DSM_DW-1:0] sample_in,
  // Modulated bit
  output logic bit_out
);
  import tcc_pkg::*;

  tcc_dsm_state_t st_reg;
  tcc_dsm_state_t st_next;

  // One modulator step per step pulse; everything clears when the mode is left
  always_comb
  begin
    logic signed [14:0] diff;
    logic signed [14:0] delta;
    logic [14:0] sum;
    logic signed [17:0] y;
    diff = '0;
    delta = '0;
    sum = '0;
    y = '0;
    st_next = st_reg;
    if (!enable)
    begin
      st_next = '0;
    end
    else
    begin
      if (load)
      begin
        st_next.target = sample_in;
      end
      if (step)
      begin
        // Interpolator glides an eighth of the gap per step, snaps when less than eight below the target
        diff = $signed({1'b0, st_reg.target}) - $signed({1'b0, st_reg.cur});
        delta = diff >>> `TCC_INTERP_SHIFT;
        if (!interp_en || delta == '0)
          st_next.cur = st_reg.target;
        else
          st_next.cur = 14'(15'({1'b0, st_reg.cur}) + 15'(delta));
        if (shape_en)
        begin
          // Error feedback 2e1 - e2 pushes quantisation noise to high frequency
          y = $signed({4'h0, st_reg.cur}) + (st_reg.e1 <<< 1) - st_reg.e2;
          st_next.q = (y >= `TCC_DSM_HALF);
          st_next.e2 = st_reg.e1;
          st_next.e1 = st_next.q ? y - `TCC_DSM_FULL : y;
        end
        else
        begin
          // First order: the carry of the accumulator is the bit
          sum = {1'b0, st_reg.acc} + {1'b0, st_reg.cur};
          st_next.q = sum[14];
          st_next.acc = sum[13:0];
        end
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bit_out = st_reg.q;
endmodule : tcc_dsm

/* logic/tcc_core.sv */
// Timer capture/compare channels 0 and 1 with delta-sigma mode, Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_core #(
  parameter int TICK_DIV = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire tcc_pkg::tcc_avm_req_t avm_req,
  output tcc_pkg::tcc_avm_rsp_t avm_rsp,
  // Capture sources
  input wire logic cap_pin,
  input wire logic [7:0] radio_evt,
  // Compare output and interrupt
  output logic cmp_out,
  output logic irq
);
  import tcc_pkg::*;

  // Divider counter is eight bits wide
  if (TICK_DIV < 1 || TICK_DIV > 256)
  begin : g_bad_div
    $error("TICK_DIV must lie in 1..256");
  end

  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
  localparam tcc_state_t RST_ST = '{
    ch0_ctl: tcc_ctl_t'(`TCC_CTL_RST),
    ch1_ctl: tcc_ctl_t'(`TCC_CTL_RST),
    mode: TCC_MODE_STOP,
    irq_en: `TCC_IEN_RST,
    waitreq: 1'b1,
    default: '0
  };

  tcc_state_t st_reg;
  tcc_state_t st_next;
  logic tick;
  logic eq0;
  logic eq1;
  logic dsm_on;
  logic dsm_step;
  logic dsm_load;
  logic dsm_bit;
  logic cap_fire;
  logic wr_ok;
  logic [7:0] wd;
  logic [7:0] rd;

  // Timer tick, matches and mode decode
  assign tick = (st_reg.tick_cnt == TICK_LAST);
  assign eq0 = (st_reg.count == st_reg.ch0_val);
  assign eq1 = (st_reg.count == st_reg.ch1_val);
  assign dsm_on = (st_reg.ch1_ctl.compare_action == TCC_CMP_DSM);
  assign dsm_step = dsm_on && tick &&
    (st_reg.dsm_cnt == (st_reg.ch1_ctl.cap_cmp_sel ? `TCC_DSM_FAST : `TCC_DSM_SLOW));
  // sample rate from channel 0 period
  assign dsm_load = dsm_on && tick && eq0;
  assign wr_ok = avm_req.write && !st_reg.waitreq && avm_req.byteenable[0];
  assign wd = avm_req.writedata[7:0];

  // Capture trigger; the edge detector looks only at the second sync stage
  always_comb
  begin
    logic rise;
    logic fall;
    rise = st_reg.cap_s2 && !st_reg.cap_prev;
    fall = !st_reg.cap_s2 && st_reg.cap_prev;
    cap_fire = 1'b0;
    if (!dsm_on && !st_reg.ch1_ctl.cap_cmp_sel)
    begin
      if (st_reg.ch1_ctl.capture_source_sel)
        cap_fire = |(radio_evt & st_reg.rf_mask);
      else
        cap_fire = (st_reg.ch1_ctl.capture_edge_sel[0] && rise) ||
          (st_reg.ch1_ctl.capture_edge_sel[1] && fall);
    end
  end

  // Register read decode; unmapped addresses read as zero
  always_comb
  begin
    rd = '0;
    case (avm_req.address)
      `TCC_ADDR(`TCC_IDX_CH0_LO): rd = st_reg.ch0_val[7:0];
      `TCC_ADDR(`TCC_IDX_CH0_HI): rd = st_reg.ch0_val[15:8];
      `TCC_ADDR(`TCC_IDX_CH1_LO): rd = st_reg.ch1_val[7:0];
      `TCC_ADDR(`TCC_IDX_CH1_HI): rd = st_reg.ch1_val[15:8];
      `TCC_ADDR(`TCC_IDX_CTL0): rd = st_reg.ch0_ctl;
      `TCC_ADDR(`TCC_IDX_CTL1): rd = st_reg.ch1_ctl;
      `TCC_ADDR(`TCC_IDX_RFMASK): rd = st_reg.rf_mask;
      `TCC_ADDR(`TCC_IDX_TMODE): rd = {6'h00, st_reg.mode};
      `TCC_ADDR(`TCC_IDX_ISTAT): rd = {6'h00, st_reg.irq_stat};
      `TCC_ADDR(`TCC_IDX_IEN): rd = {6'h00, st_reg.irq_en};
      `TCC_ADDR(`TCC_IDX_CNT_LO): rd = st_reg.count[7:0];
      `TCC_ADDR(`TCC_IDX_CNT_HI): rd = st_reg.count[15:8];
      default: rd = '0;
    endcase
  end

  // Next state: bus first, hardware events afterwards so they win
  always_comb
  begin
    logic up_match;
    logic dn_match;
    logic updn;
    logic [1:0] set_ev;
    st_next = st_reg;
    up_match = eq1 && !st_reg.down;
    dn_match = eq1 && st_reg.down;
    updn = (st_reg.mode == TCC_MODE_UPDN);
    set_ev = '0;
    // Pin synchroniser and edge history
    st_next.cap_s1 = cap_pin;
    st_next.cap_s2 = st_reg.cap_s1;
    st_next.cap_prev = st_reg.cap_s2;
    // One wait cycle, then a single cycle with waitrequest low
    st_next.waitreq = !((avm_req.read || avm_req.write) && st_reg.waitreq);
    st_next.rdata = {24'h000000, rd};
    if (wr_ok)
    begin
      case (avm_req.address)
        `TCC_ADDR(`TCC_IDX_CH0_LO): st_next.ch0_val[7:0] = wd;
        `TCC_ADDR(`TCC_IDX_CH0_HI): st_next.ch0_val[15:8] = wd;
        `TCC_ADDR(`TCC_IDX_CH1_LO): st_next.ch1_val[7:0] = wd;
        `TCC_ADDR(`TCC_IDX_CH1_HI): st_next.ch1_val[15:8] = wd;
        `TCC_ADDR(`TCC_IDX_CTL0): st_next.ch0_ctl = tcc_ctl_t'(wd);
        `TCC_ADDR(`TCC_IDX_CTL1): st_next.ch1_ctl = tcc_ctl_t'(wd);
        `TCC_ADDR(`TCC_IDX_RFMASK): st_next.rf_mask = wd;
        `TCC_ADDR(`TCC_IDX_TMODE): st_next.mode = tcc_mode_t'(wd[1:0]);
        `TCC_ADDR(`TCC_IDX_ISTAT): st_next.irq_stat = st_reg.irq_stat & ~wd[1:0];
        `TCC_ADDR(`TCC_IDX_IEN): st_next.irq_en = wd[1:0];
        default: st_next.rf_mask = st_next.rf_mask;
      endcase
    end
    // Tick divider and modulator step divider
    st_next.tick_cnt = tick ? '0 : 8'(st_reg.tick_cnt + 8'h01);
    if (!dsm_on)
      st_next.dsm_cnt = '0;
    else if (dsm_step)
      st_next.dsm_cnt = '0;
    else if (tick)
      st_next.dsm_cnt = 3'(st_reg.dsm_cnt + 3'h1);
    if (tick)
    begin
      case (st_reg.mode)
        TCC_MODE_STOP: st_next.count = st_reg.count;
        TCC_MODE_FREE: st_next.count = 16'(st_reg.count + 16'h0001);
        TCC_MODE_MOD: st_next.count = eq0 ? '0 : 16'(st_reg.count + 16'h0001);
        TCC_MODE_UPDN:
        begin
          if (!st_reg.down)
          begin
            if (st_reg.count >= st_reg.ch0_val)
            begin
              st_next.down = (st_reg.count != '0);
              st_next.count = (st_reg.count == '0) ? '0 : 16'(st_reg.count - 16'h0001);
            end
            else
              st_next.count = 16'(st_reg.count + 16'h0001);
          end
          else if (st_reg.count == '0)
          begin
            st_next.down = 1'b0;
            st_next.count = (st_reg.ch0_val == '0) ? '0 : 16'h0001;
          end
          else
            st_next.count = 16'(st_reg.count - 16'h0001);
        end
        default: st_next.count = st_reg.count;
      endcase
      if (st_reg.mode != TCC_MODE_UPDN)
        st_next.down = 1'b0;
      if (st_reg.mode != TCC_MODE_STOP && eq0)
        set_ev[`TCC_ST_CH0] = 1'b1;
    end
    // Capture beats a same-cycle software write of the value
    if (cap_fire)
    begin
      st_next.ch1_val = st_reg.count;
      set_ev[`TCC_ST_CH1] = 1'b1;
    end
    // Compare actions on the output pin
    if (dsm_on)
      st_next.pin_out = dsm_bit;
    else if (tick && st_reg.ch1_ctl.cap_cmp_sel)
    begin
      if (eq1)
        set_ev[`TCC_ST_CH1] = 1'b1;
      case (st_reg.ch1_ctl.compare_action)
        TCC_CMP_SET: if (eq1) st_next.pin_out = 1'b1;
        TCC_CMP_CLR: if (eq1) st_next.pin_out = 1'b0;
        TCC_CMP_TGL: if (eq1) st_next.pin_out = !st_reg.pin_out;
        TCC_CMP_SETUP:
        begin
          // set up, clear at zero or down
          if (up_match)
            st_next.pin_out = 1'b1;
          else if (updn ? dn_match : (st_reg.count == '0))
            st_next.pin_out = 1'b0;
        end
        TCC_CMP_CLRUP:
        begin
          // clear up, set at zero or down
          if (up_match)
            st_next.pin_out = 1'b0;
          else if (updn ? dn_match : (st_reg.count == '0))
            st_next.pin_out = 1'b1;
        end
        TCC_CMP_SET1:
        begin
          // set on ch1, clear on ch0
          if (eq1)
            st_next.pin_out = 1'b1;
          else if (eq0)
            st_next.pin_out = 1'b0;
        end
        TCC_CMP_CLR1:
        begin
          // clear on ch1, set on ch0
          if (eq1)
            st_next.pin_out = 1'b0;
          else if (eq0)
            st_next.pin_out = 1'b1;
        end
        default: st_next.pin_out = st_reg.pin_out;
      endcase
    end
    // Sticky status: a set in the clearing cycle survives
    st_next.irq_stat = st_next.irq_stat | set_ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en &
      {st_next.ch0_ctl.chan_irq_mask, st_next.ch1_ctl.chan_irq_mask});
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= RST_ST;
    else
      st_reg <= st_next;
  end

  // channel 1 high byte is the upper modulator data byte
  // field decode: only 00 shapes, 10 acts as 11
  tcc_dsm u_dsm (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(dsm_on),
    .step(dsm_step),
    .load(dsm_load),
    .interp_en(!st_reg.ch1_ctl.capture_edge_sel[1]),
    .shape_en(st_reg.ch1_ctl.capture_edge_sel == 2'b00),
    .sample_in(st_reg.ch1_val[15:`TCC_DSM_LSB]),
    .bit_out(dsm_bit)
  );

  // Outputs straight from the state register
  assign avm_rsp.readdata = st_reg.rdata;
  assign avm_rsp.waitrequest = st_reg.waitreq;
  assign cmp_out = st_reg.pin_out;
  assign irq = st_reg.irq;

  // Checks
  property p_ch0_lo_wr;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && avm_req.address == `TCC_ADDR(`TCC_IDX_CH0_LO) |=> st_reg.ch0_val[7:0] == $past(wd);
  endproperty
  a_ch0_lo_wr: assert property (p_ch0_lo_wr) else $error("ch0 low byte not written");

  property p_ch1_hi_wr;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !cap_fire && avm_req.address == `TCC_ADDR(`TCC_IDX_CH1_HI)
      |=> st_reg.ch1_val[15:8] == $past(wd);
  endproperty
  a_ch1_hi_wr: assert property (p_ch1_hi_wr) else $error("ch1 high byte not written");

  property p_rf_cap;
    @(posedge mclk) disable iff (!arst_n)
    !dsm_on && !st_reg.ch1_ctl.cap_cmp_sel && st_reg.ch1_ctl.capture_source_sel &&
      |(radio_evt & st_reg.rf_mask) |=> st_reg.ch1_val == $past(st_reg.count) && st_reg.irq_stat[`TCC_ST_CH1];
  endproperty
  a_rf_cap: assert property (p_rf_cap) else $error("radio event capture missed");

  property p_irq_line;
    @(posedge mclk) disable iff (!arst_n)
    st_reg.irq_stat[`TCC_ST_CH1] && st_reg.irq_en[`TCC_ST_CH1] && st_reg.ch1_ctl.chan_irq_mask |-> irq;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt not raised");

  property p_tgl;
    @(posedge mclk) disable iff (!arst_n)
    tick && eq1 && st_reg.ch1_ctl.cap_cmp_sel && st_reg.ch1_ctl.compare_action == TCC_CMP_TGL
      |=> cmp_out != $past(cmp_out);
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle on compare missed");

  property p_set1clr0;
    @(posedge mclk) disable iff (!arst_n)
    tick && !eq1 && eq0 && st_reg.ch1_ctl.cap_cmp_sel && st_reg.ch1_ctl.compare_action == TCC_CMP_SET1
      |=> !cmp_out;
  endproperty
  a_set1clr0: assert property (p_set1clr0) else $error("clear on ch0 match missed");

  property p_pin_cap;
    @(posedge mclk) disable iff (!arst_n)
    !dsm_on && !st_reg.ch1_ctl.cap_cmp_sel && !st_reg.ch1_ctl.capture_source_sel &&
      st_reg.ch1_ctl.capture_edge_sel == 2'b01 && st_reg.cap_s2 && !st_reg.cap_prev
      |=> st_reg.ch1_val == $past(st_reg.count);
  endproperty
  a_pin_cap: assert property (p_pin_cap) else $error("rising edge capture missed");

  property p_mod_wrap;
    @(posedge mclk) disable iff (!arst_n)
    tick && st_reg.mode == TCC_MODE_MOD && eq0 |=> st_reg.count == '0;
  endproperty
  a_mod_wrap: assert property (p_mod_wrap) else $error("modulo wrap missed");

  property p_updn_turn;
    @(posedge mclk) disable iff (!arst_n)
    tick && st_reg.mode == TCC_MODE_UPDN && !st_reg.down && eq0 && st_reg.ch0_val != '0 |=> st_reg.down;
  endproperty
  a_updn_turn: assert property (p_updn_turn) else $error("up/down turn missed");

  property p_dsm_slow;
    @(posedge mclk) disable iff (!arst_n)
    dsm_step && !st_reg.ch1_ctl.cap_cmp_sel |-> st_reg.dsm_cnt == `TCC_DSM_SLOW;
  endproperty
  a_dsm_slow: assert property (p_dsm_slow) else $error("slow modulator step off");

  c_pin_cap: cover property (@(posedge mclk) disable iff (!arst_n) cap_fire);
  c_dsm_step: cover property (@(posedge mclk) disable iff (!arst_n) dsm_step);
  c_irq: cover property (@(posedge mclk) disable iff (!arst_n) irq);
endmodule : tcc_core

/* dv/tcc_pin_model.sv */
// Far-side pin model: drives the capture pin and tallies the compare output
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Commands from the bench
  input wire logic pin_level,
  input wire logic tally_clr,
  // Pins of the block
  input wire logic cmp_out,
  output logic cap_pin,
  // High cycles seen on the compare output
  output logic [15:0] ones
);
  // Pin moves just after an edge; an unknown output is never counted as high
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_pin <= 1'b0;
      ones <= 16'h0000;
    end
    else
    begin
      cap_pin <= pin_level;
      ones <= tally_clr ? 16'h0000 : ones + {15'h0000, cmp_out === 1'b1};
    end
  end
endmodule : tcc_pin_model

/* dv/timer_cc_channels_dsm_tb.sv */
// Self-checking bench of the capture/compare block
`timescale 1ns/1ps
`include "tcc_map.svh"
module timer_cc_channels_dsm_tb;
  import tcc_pkg::*;
  localparam int P = 20;
  localparam int M = 5;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  tcc_avm_req_t avm_req = '0;
  tcc_avm_rsp_t avm_rsp;
  logic cap_pin;
  logic [7:0] radio_evt = 8'h00;
  logic cmp_out;
  logic irq;
  logic pin_level = 1'b0;
  logic tally_clr = 1'b0;
  logic [15:0] ones;
  logic [15:0] got;
  logic [7:0] rd;
  logic [7:0] v;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] idx_tab [6] = '{`TCC_IDX_CH0_LO, `TCC_IDX_CH0_HI, `TCC_IDX_CH1_HI, `TCC_IDX_CTL0, `TCC_IDX_CTL1, 8'h10};
  logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, `TCC_CTL_RST, `TCC_CTL_RST, 8'h00};
  logic [7:0] dsm_tab [5] = '{8'h7b, 8'h7a, 8'h7f, 8'h79, 8'h78};
  logic [7:0] evt_tab [4];

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  tcc_core #(.TICK_DIV(1)) tcc_core_inst (.mclk(mclk), .arst_n(arst_n), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .cap_pin(cap_pin), .radio_evt(radio_evt), .cmp_out(cmp_out), .irq(irq));
  tcc_pin_model tcc_pin_model_inst (.mclk(mclk), .arst_n(arst_n), .pin_level(pin_level), .tally_clr(tally_clr),
    .cmp_out(cmp_out), .cap_pin(cap_pin), .ones(ones));

  // Verdict and end of run
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Exact value comparison
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Range comparison, for modulator density
  task automatic chk_rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    n_compared++;
    if (((g >= lo) && (g <= hi)) !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, g, lo, hi);
    end
  endtask : chk_rng

  // One Avalon transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avm_req <= '{read: !is_wr, write: is_wr, address: {idx, 2'b00}, writedata: {24'h000000, d}, byteenable: 4'h1};
    // Each pass sees waitrequest as it stood just before the rising edge
    @(posedge mclk);
    while (avm_rsp.waitrequest !== 1'b0 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100)
      n_mismatch++;
    // Read data taken and request released at the edge that saw waitrequest low
    q = avm_rsp.readdata[7:0];
    avm_req <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  // High cycles of the compare output over n edges
  task automatic measure(input int n, output logic [15:0] g);
    @(posedge mclk);
    tally_clr <= 1'b1;
    @(posedge mclk);
    tally_clr <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    g = ones;
  endtask : measure

  // High cycles over two periods: modulo 0..P, up/down 0..P..0, match at M
  function automatic logic [15:0] ones_exp(input logic [2:0] act, input logic updn);
    if (updn)
      return (act == 3'b011) ? 16'(4 * (P - M)) : 16'(4 * M);
    case (act)
      3'b000: return 16'(2 * (P + 1));
      3'b001: return 16'h0000;
      3'b010: return 16'(P + 1);
      3'b011: return 16'(2 * (P - M + 1));
      3'b100: return 16'(2 * M);
      3'b101: return 16'(2 * (P - M));
      default: return 16'(2 * (M + 1));
    endcase
  endfunction : ones_exp

  task automatic cmp_run(input logic [2:0] act, input logic updn);
    logic [15:0] g;
    wr(`TCC_IDX_TMODE, updn ? 8'h03 : 8'h02);
    wr(`TCC_IDX_CTL1, {2'b01, act, 1'b1, 2'b00});
    repeat (90) @(posedge mclk);
    measure(updn ? 80 : 42, g);
    chk(g, ones_exp(act, updn));
    $display("test compare action %b updown %b done", act, updn);
  endtask : cmp_run

  // Watchdog, well beyond the expected run length
  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(36194));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, idx_tab[i], 8'h00, rd);
      chk(rd, rst_tab[i]);
    end
    // Random write and readback
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr(idx_tab[i], v);
      bus(1'b0, idx_tab[i], 8'h00, rd);
      chk(rd, v);
    end
    $display("test registers done");
    // Compare actions in modulo and up/down counting
    wr(`TCC_IDX_CH0_LO, 8'(P));
    wr(`TCC_IDX_CH0_HI, 8'h00);
    wr(`TCC_IDX_CH1_LO, 8'(M));
    wr(`TCC_IDX_CH1_HI, 8'h00);
    for (int a = 0; a < 7; a++)
      cmp_run(3'(a), 1'b0);
    cmp_run(3'b011, 1'b1);
    cmp_run(3'b100, 1'b1);
    // Modulator density follows the channel 1 high byte at each of the five settings in dsm_tab
    wr(`TCC_IDX_TMODE, 8'h02);
    wr(`TCC_IDX_CH1_LO, 8'h00);
    v = 8'h40 + 8'($urandom % 128);
    wr(`TCC_IDX_CH1_HI, v);
    for (int i = 0; i < 5; i++)
    begin
      wr(`TCC_IDX_CTL1, dsm_tab[i]);
      repeat (2000) @(posedge mclk);
      measure(512, got);
      chk_rng(got, 16'(2 * v - 40), 16'(2 * v + 40));
    end
    $display("test modulator done");
    // Pin capture on each edge selection, interrupt follows status
    wr(`TCC_IDX_TMODE, 8'h01);
    wr(`TCC_IDX_IEN, 8'h01);
    for (int e = 0; e < 4; e++)
    begin
      wr(`TCC_IDX_CTL1, {2'b01, 3'b000, 1'b0, 2'(e)});
      for (int l = 1; l >= 0; l--)
      begin
        wr(`TCC_IDX_ISTAT, 8'h03);
        pin_level <= 1'(l);
        repeat (6) @(posedge mclk);
        bus(1'b0, `TCC_IDX_ISTAT, 8'h00, rd);
        chk({15'h0000, rd[0]}, {15'h0000, (l == 1) ? 1'(e) : 1'(e >> 1)});
        chk({15'h0000, irq}, {15'h0000, (l == 1) ? 1'(e) : 1'(e >> 1)});
      end
    end
    // Mask hides a pending event, write of one clears it
    wr(`TCC_IDX_CTL1, 8'h03);
    // The line drops at the write's own edge, so look once it has settled
    @(negedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    wr(`TCC_IDX_ISTAT, 8'h01);
    bus(1'b0, `TCC_IDX_ISTAT, 8'h00, rd);
    chk({15'h0000, rd[0]}, 16'h0000);
    $display("test pin capture done");
    // Radio events gated by the event mask
    evt_tab = '{8'h04, 8'hfb, 8'($urandom), 8'($urandom)};
    wr(`TCC_IDX_RFMASK, 8'h04);
    wr(`TCC_IDX_CTL1, 8'hc1);
    for (int i = 0; i < 4; i++)
    begin
      wr(`TCC_IDX_ISTAT, 8'h03);
      radio_evt <= evt_tab[i];
      @(posedge mclk);
      radio_evt <= 8'h00;
      repeat (3) @(posedge mclk);
      bus(1'b0, `TCC_IDX_ISTAT, 8'h00, rd);
      chk({15'h0000, rd[0]}, {15'h0000, evt_tab[i][2]});
    end
    $display("test radio capture done");
    wrap_up();
  end
endmodule : timer_cc_channels_dsm_tb
